//--- verification/nibble_alu_checker.sv
// Purpose: concurrent checks on the nibble datapath ports.
// Assumes: one clock, reset asynchronous and active high.
// Notes: ops taken under a pending skip are only checked for no effect.
`timescale 1ns/1ps
module nibble_alu_checker
  import nibble_alu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic op_valid_in,
  input wire op_t op_code_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [7:0] imm_in,
  input wire logic [3:0] mem_rdata_in,
  input wire logic op_ready_out,
  input wire logic op_done_out,
  input wire logic skip_pending_out,
  input wire logic carry_flag_out,
  input wire logic [7:0] accum_pair_out,
  input wire logic [7:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [3:0] mem_wdata_out
);
  logic take;
  logic run;
  assign take = op_valid_in && op_ready_out;
  assign run = take && !skip_pending_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  busy_after_take_a:
  assert property (run && op_code_in != OP_NOP |=> !op_ready_out)
    else $error("busy missing after take");
  discard_skipped_a:
  assert property (take && skip_pending_out |=> op_done_out &&
    !skip_pending_out && !mem_wr_out && $stable(accum_pair_out) &&
    $stable(carry_flag_out))
    else $error("skipped op had an effect");
  reg_latency_a:
  assert property (run && op_code_in inside {OP_INC_REG, OP_DEC_REG}
    |=> !op_done_out ##1 op_done_out)
    else $error("register op done late");
  inc_mem_write_a:
  assert property (run && op_code_in == OP_INC_MEM_DIR |=> mem_rd_out &&
    mem_addr_out == $past(imm_in) ##2 mem_wr_out &&
    mem_wdata_out == $past(mem_rdata_in) + 4'h1)
    else $error("memory increment wrong");
  carry_set_a:
  assert property (run && op_code_in == OP_CARRY_SET |=> ##1 carry_flag_out)
    else $error("carry not set");
  carry_invert_a:
  assert property (run && op_code_in == OP_CARRY_INV
    |=> ##1 carry_flag_out != $past(carry_flag_out, 2))
    else $error("carry not inverted");
  acc_complement_a:
  assert property (run && op_code_in == OP_NOT_ACC |=> ##1
    accum_pair_out[3:0] == ~$past(accum_pair_out[3:0], 2))
    else $error("complement wrong");
  rotate_carry_a:
  assert property (run && op_code_in == OP_ROT_CARRY |=> ##1
    accum_pair_out[3:0] == {$past(carry_flag_out, 2),
    $past(accum_pair_out[3:1], 2)} &&
    carry_flag_out == $past(accum_pair_out[0], 2))
    else $error("rotate wrong");
  dec_wrap_skip_a:
  assert property (run && op_code_in == OP_DEC_REG && reg_sel_in == 3'h1
    && accum_pair_out[3:0] == 4'h0 |=> ##1 skip_pending_out &&
    accum_pair_out[3:0] == 4'hF)
    else $error("decrement wrap without skip");
  carry_kept_a:
  assert property (run && op_code_in inside {OP_AND_IMM, OP_OR_IMM,
    OP_XOR_IMM, OP_INC_REG, OP_DEC_REG, OP_NOT_ACC}
    |=> $stable(carry_flag_out)[*2])
    else $error("carry changed");
endmodule

bind nibble_alu nibble_alu_checker u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
  .op_code_in(op_code_in), .reg_sel_in(reg_sel_in), .imm_in(imm_in),
  .mem_rdata_in(mem_rdata_in), .op_ready_out(op_ready_out),
  .op_done_out(op_done_out), .skip_pending_out(skip_pending_out),
  .carry_flag_out(carry_flag_out), .accum_pair_out(accum_pair_out),
  .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out)
);

//--- verification/tb_top.sv
// Purpose: directed checks of the nibble datapath.
// Assumes: memory answers one cycle after a read strobe.
// Notes: no loader exists, so registers are built up by the ops.
`timescale 1ns/1ps
module tb_top;
  import nibble_alu_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic op_valid_in = 1'b0;
  op_t op_code_in = OP_NOP;
  logic [2:0] sel = 3'h0;
  logic [7:0] imm_in = 8'h00;
  logic [1:0] bit_sel_in = 2'h0;
  bit_mode_t bit_mode_in = BM_DIRECT;
  logic [3:0] mem_rdata_in = 4'h0;
  logic [3:0] dbg_idx_in = 4'h0;
  logic op_ready_out, op_done_out, skip_pending_out, carry_flag_out;
  logic mem_rd_out, mem_wr_out;
  logic [7:0] accum_pair_out, mem_addr_out;
  logic [3:0] dbg_nibble_out, mem_wdata_out;
  logic [3:0] mem [256];
  int err_total = 0;
  int n_tests = 0;

  nibble_alu u_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .reg_sel_in(sel), .pair_sel_in(sel), .imm_in(imm_in),
    .bit_sel_in(bit_sel_in), .bit_mode_in(bit_mode_in),
    .mem_rdata_in(mem_rdata_in), .dbg_idx_in(dbg_idx_in),
    .op_ready_out(op_ready_out), .op_done_out(op_done_out),
    .skip_pending_out(skip_pending_out), .carry_flag_out(carry_flag_out),
    .accum_pair_out(accum_pair_out), .dbg_nibble_out(dbg_nibble_out),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out)
  );

  initial forever #4 sys_clk_in = ~sys_clk_in;

  // Idle read bus toggles so a late sample never sees stale data
  always @(posedge sys_clk_in) begin
    if (mem_rd_out) mem_rdata_in <= mem[mem_addr_out];
    else mem_rdata_in <= ~mem_rdata_in;
    if (mem_wr_out) mem[mem_addr_out] <= mem_wdata_out;
  end

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic op(input op_t c, input logic [7:0] i = 8'h00,
                    input logic [2:0] p = 3'h0,
                    input bit_mode_t m = BM_DIRECT);
    bit dn;
    dn = 1'b0;
    @(posedge sys_clk_in);
    op_valid_in <= 1'b1;
    op_code_in <= c;
    imm_in <= i;
    sel <= p;
    bit_sel_in <= 2'h1;
    bit_mode_in <= m;
    @(posedge sys_clk_in);
    op_valid_in <= 1'b0;
    for (int k = 0; k < 8 && !dn; k++) begin
      #1;
      dn = (op_done_out === 1'b1);
      if (!dn) @(posedge sys_clk_in);
    end
    chk("done", {7'h0, dn}, 8'h01);
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic skp(input logic e);
    chk("skip", {7'h0, skip_pending_out}, {7'h0, e});
    if (e) op(OP_NOP);
  endtask

  task automatic cy(input logic e);
    chk("carry", {7'h0, carry_flag_out}, {7'h0, e});
  endtask

  task automatic acc(input logic [7:0] e);
    chk("accum", accum_pair_out, e);
  endtask

  task automatic reg_is(input logic [3:0] x, input logic [3:0] e);
    @(posedge sys_clk_in);
    dbg_idx_in <= x;
    @(posedge sys_clk_in);
    #1;
    chk("register", {4'h0, dbg_nibble_out}, {4'h0, e});
  endtask

  task automatic t_incdec();
    op(OP_DEC_REG, 8'h00, 3'h1);
    acc(8'h0F);
    chk("skip", {7'h0, skip_pending_out}, 8'h01);
    op(OP_INC_REG, 8'h00, 3'h1);
    acc(8'h0F);
    skp(1'b0);
    op(OP_INC_REG, 8'h00, 3'h1);
    acc(8'h00);
    skp(1'b1);
    $display("test incdec done");
  endtask

  task automatic t_logic();
    op(OP_CARRY_SET);
    op(OP_XOR_IMM, 8'h05);
    acc(8'h05);
    op(OP_OR_IMM, 8'h09);
    acc(8'h0D);
    op(OP_AND_IMM, 8'h06);
    acc(8'h04);
    op(OP_NOT_ACC);
    acc(8'h0B);
    cy(1'b1);
    op(OP_OR_DST_ACC, 8'h00, 3'h2);
    op(OP_XOR_ACC_ANY, 8'h00, 3'h2);
    acc(8'h00);
    reg_is(4'h5, 4'hB);
    $display("test logic done");
  endtask

  task automatic t_carry();
    op(OP_CARRY_INV);
    cy(1'b0);
    op(OP_CARRY_TEST);
    skp(1'b0);
    op(OP_CARRY_INV);
    op(OP_CARRY_TEST);
    skp(1'b1);
    op(OP_XOR_IMM, 8'h0B);
    op(OP_CARRY_CLR);
    cy(1'b0);
    op(OP_ROT_CARRY);
    acc(8'h05);
    cy(1'b1);
    $display("test carry done");
  endtask

  task automatic t_pair();
    op(OP_SBB_ACC_ANY, 8'h00, 3'h2);
    acc(8'hF9);
    cy(1'b1);
    op(OP_SBB_DST_ACC, 8'h00, 3'h0);
    acc(8'hF9);
    cy(1'b1);
    op(OP_SBB_DST_ACC, 8'h00, 3'h2);
    reg_is(4'h4, 4'h1);
    reg_is(4'h5, 4'h1);
    op(OP_SBB_ACC_ANY, 8'h00, 3'h2);
    acc(8'hE7);
    cy(1'b0);
    op(OP_DEC_PAIR, 8'h00, 3'h1);
    skp(1'b1);
    op(OP_INC_PAIR, 8'h00, 3'h1);
    skp(1'b1);
    op(OP_EQ_ACC_PAIR, 8'h00, 3'h0);
    skp(1'b1);
    $display("test pair done");
  endtask

  function automatic logic [7:0] bit_addr(input bit_mode_t m,
                                          input logic [7:0] i);
    case (m)
      BM_FIXED: bit_addr = {4'hF, i[3:0]};
      BM_PTR_LOW: bit_addr = {i[7:2], 2'h0};
      BM_HIGH_REL: bit_addr = {4'h0, i[3:0]};
      default: bit_addr = i;
    endcase
  endfunction

  // Pointer pair is 01 here: pointer-low picks bit 1, high page is 0
  task automatic t_mem();
    bit_mode_t m;
    logic [7:0] i;
    logic [7:0] a;
    mem[0] = 4'h9;
    op(OP_AND_MEM);
    acc(8'hE1);
    op(OP_EQ_PTR_IMM, 8'h09);
    skp(1'b1);
    op(OP_EQ_ACC_REG, 8'h00, 3'h1);
    skp(1'b1);
    mem[8'h20] = 4'hF;
    op(OP_INC_MEM_DIR, 8'h20);
    chk("memory", {4'h0, mem[8'h20]}, 8'h00);
    skp(1'b1);
    mem[0] = 4'h1;
    mem[1] = 4'hE;
    op(OP_INC_PAIR, 8'h00, 3'h1);
    skp(1'b0);
    op(OP_EQ_WIDE_PTR);
    skp(1'b1);
    for (int j = 0; j < 4; j++) begin
      m = bit_mode_t'(j);
      i = 8'h40 + j[7:0];
      a = bit_addr(m, i);
      mem[a] = 4'hF;
      op(OP_BIT_CLR, i, 3'h0, m);
      chk("bit clear", {4'h0, mem[a]}, 8'h0D);
      mem[a] = 4'h0;
      op(OP_BIT_SET, i, 3'h0, m);
      chk("bit set", {4'h0, mem[a]}, 8'h02);
      op(OP_BIT_TEST_F, i, 3'h0, m);
      skp(1'b0);
      op(OP_BIT_TEST_T, i, 3'h0, m);
      skp(1'b1);
      op(OP_BIT_TEST_CLR, i, 3'h0, m);
      chk("test clear", {4'h0, mem[a]}, 8'h00);
      skp(1'b1);
    end
    $display("test memory done");
  endtask

  // Ops the other tests leave out; pointer still 01, memory[1] is E
  task automatic t_more();
    op(OP_OR_MEM);
    acc(8'hEF);
    op(OP_XOR_MEM);
    acc(8'hE1);
    op(OP_EQ_ACC_PTR);
    skp(1'b0);
    op(OP_INC_MEM_PTR);
    chk("memory", {4'h0, mem[1]}, 8'h0F);
    skp(1'b0);
    op(OP_EQ_REG_IMM, 8'h0E, 3'h0);
    skp(1'b1);
    // Alternate-bank pair 4 as destination and as operand
    op(OP_OR_DST_ACC, 8'h00, 3'h4);
    reg_is(4'h8, 4'hE);
    op(OP_DEC_PAIR, 8'h00, 3'h4);
    skp(1'b0);
    op(OP_AND_DST_ACC, 8'h00, 3'h2);
    reg_is(4'h4, 4'h0);
    op(OP_AND_ACC_ANY, 8'h00, 3'h4);
    acc(8'hE0);
    op(OP_OR_ACC_ANY, 8'h00, 3'h2);
    acc(8'hE1);
    op(OP_XOR_DST_ACC, 8'h00, 3'h4);
    reg_is(4'h8, 4'h0);
    op(OP_EQ_ACC_PAIR, 8'h00, 3'h4);
    skp(1'b0);
    $display("test more done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    foreach (mem[k]) mem[k] = 4'h0;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    t_incdec();
    t_logic();
    t_carry();
    t_pair();
    t_mem();
    t_more();
    print_verdict();
  end

  // About 80 ops of under ten cycles each; this leaves wide margin
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule

//--- verilog/bit_address_unit.sv
// Purpose: memory address and bit position for bit operations.
// Assumes: 8-bit data memory address inside the selected bank.
// Notes: pointer-low mode takes the bit from L and the pair from L[3:2].
`timescale 1ns/1ps
module bit_address_unit
  import nibble_alu_pkg::*;
(
  input wire bit_mode_t mode_in,
  input wire logic [7:0] imm_in,
  input wire logic [1:0] bit_sel_in,
  input wire logic [3:0] high_in,
  input wire logic [3:0] low_in,
  output logic [7:0] addr_out,
  output logic [1:0] bit_out
);
  always_comb begin
    bit_out = bit_sel_in;
    case (mode_in)
      BM_DIRECT: addr_out = imm_in; // see RULE_18
      BM_FIXED: addr_out = {FIXED_PAGE, imm_in[3:0]}; // see RULE_19
      BM_PTR_LOW: begin
        addr_out = {imm_in[7:2], low_in[3:2]}; // see RULE_19
        bit_out = low_in[1:0];
      end
      BM_HIGH_REL: addr_out = {high_in, imm_in[3:0]}; // see RULE_19
      default: addr_out = imm_in;
    endcase
  end
endmodule

//--- verilog/nibble_alu.sv
// Purpose: execution datapath for logic, skip and bit operations.
// Assumes: data memory answers a read one cycle after mem_rd_out.
// Notes: register file and carry live here; skips are held until used.
`timescale 1ns/1ps
module nibble_alu
  import nibble_alu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic op_valid_in,
  input wire op_t op_code_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [2:0] pair_sel_in,
  input wire logic [7:0] imm_in,
  input wire logic [1:0] bit_sel_in,
  input wire bit_mode_t bit_mode_in,
  input wire logic [3:0] mem_rdata_in,
  input wire logic [3:0] dbg_idx_in,
  output logic op_ready_out,
  output logic op_done_out,
  output logic skip_pending_out,
  output logic carry_flag_out,
  output logic [7:0] accum_pair_out,
  output logic [3:0] dbg_nibble_out,
  output logic [7:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [3:0] mem_wdata_out
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DATA} state_t;

  state_t state_reg;
  logic [3:0] rf_reg [0:15];
  logic carry_reg, skip_reg, second_reg;
  op_t op_reg;
  logic [2:0] rsel_reg, psel_reg;
  logic [7:0] imm_reg;
  logic [1:0] bpos_reg;
  logic [3:0] first_reg;
  logic [7:0] addr_reg;
  logic rd_reg, wr_reg, done_reg;
  logic [3:0] wdata_reg, dbg_reg;

  logic [3:0] acc, xr, rg, mem_nib;
  logic [7:0] accp, anyp;
  logic [1:0] ba_bit;
  logic [7:0] ba_addr, acc_addr;
  logic acc_mem;
  logic accept;

  logic_fn_t lu_fn;
  logic [7:0] lu_a, lu_b, lu_y;
  logic lu_borrow;

  logic nw_en, pw_en, cy_we, cy_val, sk, mw_en, again;
  logic [3:0] nw_idx, nw_data, mw_data;
  logic [2:0] pw_sel;
  logic [7:0] pw_data;

  assign acc = rf_reg[IDX_A];
  assign xr = rf_reg[IDX_X];
  assign accp = {xr, acc};
  assign anyp = {rf_reg[pair_idx(psel_reg, 1'b0)],
                 rf_reg[pair_idx(psel_reg, 1'b1)]};
  assign rg = rf_reg[{1'b0, rsel_reg}];
  assign mem_nib = mem_rdata_in;
  assign accept = op_valid_in && state_reg == S_IDLE;

  assign op_ready_out = state_reg == S_IDLE;
  assign op_done_out = done_reg;
  assign skip_pending_out = skip_reg;
  assign carry_flag_out = carry_reg;
  assign accum_pair_out = accp;
  assign dbg_nibble_out = dbg_reg;
  assign mem_addr_out = addr_reg;
  assign mem_rd_out = rd_reg;
  assign mem_wr_out = wr_reg;
  assign mem_wdata_out = wdata_reg;

  bit_address_unit bit_addr (
    .mode_in(bit_mode_in),
    .imm_in(imm_in),
    .bit_sel_in(bit_sel_in),
    .high_in(rf_reg[IDX_H]),
    .low_in(rf_reg[IDX_L]),
    .addr_out(ba_addr),
    .bit_out(ba_bit)
  );

  pair_logic_unit logic_unit (
    .fn_in(lu_fn),
    .a_in(lu_a),
    .b_in(lu_b),
    .borrow_in(carry_reg),
    .y_out(lu_y),
    .borrow_out(lu_borrow)
  );

  // Address and need for a memory read, judged on the incoming operation
  always_comb begin
    acc_mem = 1'b1;
    acc_addr = {rf_reg[IDX_H], rf_reg[IDX_L]};
    case (op_code_in)
      OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM, OP_INC_MEM_PTR,
      OP_EQ_PTR_IMM, OP_EQ_ACC_PTR: acc_addr = {rf_reg[IDX_H],
                                                rf_reg[IDX_L]};
      OP_INC_MEM_DIR: acc_addr = imm_in; // see RULE_10
      OP_EQ_WIDE_PTR:
        acc_addr = {rf_reg[IDX_H], rf_reg[IDX_L][3:1], 1'b0}; // see RULE_15
      OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST_T, OP_BIT_TEST_F,
      OP_BIT_TEST_CLR: acc_addr = ba_addr;
      default: acc_mem = 1'b0;
    endcase
  end

  // Operand steering for the shared logic unit
  always_comb begin
    lu_fn = LF_AND;
    lu_a = accp;
    lu_b = anyp;
    case (op_reg)
      OP_OR_IMM, OP_OR_MEM, OP_OR_ACC_ANY, OP_OR_DST_ACC: lu_fn = LF_OR;
      OP_XOR_IMM, OP_XOR_MEM, OP_XOR_ACC_ANY, OP_XOR_DST_ACC:
        lu_fn = LF_XOR;
      OP_SBB_ACC_ANY, OP_SBB_DST_ACC: lu_fn = LF_SUB;
      default: lu_fn = LF_AND;
    endcase
    case (op_reg)
      OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM: begin
        lu_a = {4'h0, acc};
        lu_b = {4'h0, imm_reg[3:0]};
      end
      OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM: begin
        lu_a = {4'h0, acc};
        lu_b = {4'h0, mem_nib};
      end
      OP_SBB_DST_ACC, OP_AND_DST_ACC, OP_OR_DST_ACC, OP_XOR_DST_ACC: begin
        lu_a = anyp;
        lu_b = accp;
      end
      default: lu_b = anyp;
    endcase
  end

  // Effects of the held operation, applied in the data state
  always_comb begin
    nw_en = 1'b0;
    nw_idx = IDX_A;
    nw_data = lu_y[3:0];
    pw_en = 1'b0;
    pw_sel = PAIR_ACC;
    pw_data = lu_y;
    cy_we = 1'b0;
    cy_val = carry_reg;
    sk = 1'b0;
    mw_en = 1'b0;
    mw_data = mem_nib;
    again = 1'b0;
    case (op_reg)
      OP_SBB_ACC_ANY: begin
        pw_en = 1'b1; // see RULE_01
        cy_we = 1'b1;
        cy_val = lu_borrow;
      end
      OP_SBB_DST_ACC: begin
        // Accumulator pair as destination is not a legal encoding
        pw_en = psel_reg != PAIR_ACC; // see RULE_02
        pw_sel = psel_reg; // see RULE_01
        cy_we = psel_reg != PAIR_ACC;
        cy_val = lu_borrow;
      end
      OP_AND_IMM, OP_AND_MEM, OP_OR_IMM, OP_OR_MEM, OP_XOR_IMM,
      OP_XOR_MEM: nw_en = 1'b1; // see RULE_03 see RULE_04 see RULE_05
      OP_AND_ACC_ANY, OP_OR_ACC_ANY, OP_XOR_ACC_ANY:
        pw_en = 1'b1; // see RULE_03 see RULE_04 see RULE_05
      OP_AND_DST_ACC, OP_OR_DST_ACC, OP_XOR_DST_ACC: begin
        pw_en = psel_reg != PAIR_ACC; // see RULE_02
        pw_sel = psel_reg;
      end
      OP_ROT_CARRY: begin
        nw_en = 1'b1;
        nw_data = {carry_reg, acc[3:1]}; // see RULE_06
        cy_we = 1'b1;
        cy_val = acc[0];
      end
      OP_NOT_ACC: begin
        nw_en = 1'b1;
        nw_data = ~acc; // see RULE_07
      end
      OP_INC_REG: begin
        nw_en = 1'b1;
        nw_idx = {1'b0, rsel_reg};
        nw_data = rg + 4'h1; // see RULE_08
        sk = nw_data == 4'h0;
      end
      OP_INC_PAIR: begin
        pw_en = 1'b1;
        pw_sel = psel_reg;
        pw_data = anyp + 8'h01; // see RULE_09
        sk = pw_data == 8'h00;
      end
      OP_INC_MEM_PTR, OP_INC_MEM_DIR: begin
        mw_en = 1'b1;
        mw_data = mem_nib + 4'h1; // see RULE_10
        sk = mw_data == 4'h0;
      end
      OP_DEC_REG: begin
        nw_en = 1'b1;
        nw_idx = {1'b0, rsel_reg};
        nw_data = rg - 4'h1; // see RULE_11
        sk = nw_data == NIB_ONES;
      end
      OP_DEC_PAIR: begin
        pw_en = 1'b1;
        pw_sel = psel_reg;
        pw_data = anyp - 8'h01; // see RULE_12
        sk = pw_data == PAIR_ONES;
      end
      OP_EQ_REG_IMM: sk = rg == imm_reg[3:0]; // see RULE_13
      OP_EQ_PTR_IMM: sk = mem_nib == imm_reg[3:0]; // see RULE_13
      OP_EQ_ACC_PTR: sk = acc == mem_nib; // see RULE_14
      OP_EQ_ACC_REG: sk = acc == rg; // see RULE_14
      OP_EQ_WIDE_PTR: begin
        again = !second_reg;
        sk = second_reg && first_reg == acc && mem_nib == xr; // see RULE_15
      end
      OP_EQ_ACC_PAIR: sk = accp == anyp; // see RULE_16
      OP_CARRY_SET: begin
        cy_we = 1'b1; // see RULE_17
        cy_val = 1'b1;
      end
      OP_CARRY_CLR: begin
        cy_we = 1'b1; // see RULE_17
        cy_val = 1'b0;
      end
      OP_CARRY_INV: begin
        cy_we = 1'b1; // see RULE_17
        cy_val = ~carry_reg;
      end
      OP_CARRY_TEST: sk = carry_reg; // see RULE_17
      OP_BIT_SET: begin
        mw_en = 1'b1;
        mw_data = mem_nib | bit_mask(bpos_reg); // see RULE_18 see RULE_19
      end
      OP_BIT_CLR: begin
        mw_en = 1'b1;
        mw_data = mem_nib & ~bit_mask(bpos_reg); // see RULE_18 see RULE_19
      end
      OP_BIT_TEST_T: sk = mem_nib[bpos_reg]; // see RULE_20
      OP_BIT_TEST_F: sk = !mem_nib[bpos_reg]; // see RULE_20
      OP_BIT_TEST_CLR: begin
        // Write back only when set, so a clear bit costs no memory write cycle
        sk = mem_nib[bpos_reg]; // see RULE_21
        mw_en = mem_nib[bpos_reg];
        mw_data = mem_nib & ~bit_mask(bpos_reg);
      end
      default: sk = 1'b0;
    endcase
  end

  // Sequencing: accept, optional read wait, execute
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= S_IDLE;
      second_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          second_reg <= 1'b0;
          if (accept && !skip_reg)
            state_reg <= acc_mem ? S_WAIT : S_DATA;
        end
        S_WAIT: state_reg <= S_DATA;
        S_DATA: begin
          second_reg <= again;
          state_reg <= again ? S_WAIT : S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      op_reg <= OP_NOP;
      rsel_reg <= 3'h0;
      psel_reg <= 3'h0;
      imm_reg <= 8'h00;
      bpos_reg <= 2'h0;
      first_reg <= 4'h0;
    end else if (accept) begin
      op_reg <= op_code_in;
      rsel_reg <= reg_sel_in;
      psel_reg <= pair_sel_in;
      imm_reg <= imm_in;
      bpos_reg <= ba_bit;
    end else if (state_reg == S_DATA && again) begin
      first_reg <= mem_nib;
    end
  end

  // Memory strobes; read of the upper nibble goes to the odd address after the even one
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      addr_reg <= 8'h00;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 4'h0;
    end else begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      if (accept && !skip_reg && acc_mem) begin
        addr_reg <= acc_addr;
        rd_reg <= 1'b1;
      end else if (state_reg == S_DATA && again) begin
        addr_reg <= {addr_reg[7:1], 1'b1}; // see RULE_15
        rd_reg <= 1'b1;
      end else if (state_reg == S_DATA && mw_en) begin
        wr_reg <= 1'b1; // see RULE_10 see RULE_21
        wdata_reg <= mw_data;
      end
    end
  end

  // Register file writes
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 16; i++) begin
        rf_reg[i] <= REG_RESET;
      end
    end else if (state_reg == S_DATA) begin
      if (nw_en)
        rf_reg[nw_idx] <= nw_data;
      if (pw_en) begin
        rf_reg[pair_idx(pw_sel, 1'b0)] <= pw_data[7:4];
        rf_reg[pair_idx(pw_sel, 1'b1)] <= pw_data[3:0];
      end
    end
  end

  // Carry moves only on operations that define it
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in)
      carry_reg <= CARRY_RESET;
    else if (state_reg == S_DATA && cy_we)
      carry_reg <= cy_val; // see RULE_23
  end

  // A pending skip swallows exactly one accepted operation
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (accept && skip_reg) begin
        skip_reg <= 1'b0; // see RULE_22
        done_reg <= 1'b1;
      end else if (state_reg == S_DATA && !again) begin
        skip_reg <= sk;
        done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in)
      dbg_reg <= 4'h0;
    else
      dbg_reg <= rf_reg[dbg_idx_in];
  end
endmodule

//--- verilog/nibble_alu_pkg.sv
// What this block does
// RULE_01: Pair subtract with borrow: dest minus source minus carry; carry is borrow.
// RULE_02: With accumulator pair as source, destination is any pair except it.
// RULE_03: AND accumulator with nibble immediate or pointer memory; AND pairs.
// RULE_04: OR accumulator with nibble immediate or pointer memory; OR pairs.
// RULE_05: XOR accumulator with nibble immediate or pointer memory; XOR pairs.
// RULE_06: Rotate right through carry: bit 0 to carry, old carry to bit 3.
// RULE_07: Complement all four accumulator bits in place.
// RULE_08: Nibble register increment wraps at 16; skip next when result is zero.
// RULE_09: Primary pair increment wraps at 256; skip next when result is zero.
// RULE_10: Memory nibble increment, pointer or direct address; skip when zero.
// RULE_11: Nibble register decrement wraps; skip next when result is all ones.
// RULE_12: Any pair decrement wraps at 256; skip next when result is all ones.
// RULE_13: Skip when register or pointer memory equals immediate; nothing changes.
// RULE_14: Skip when accumulator equals a register or the pointer memory nibble.
// RULE_15: Wide memory compare uses even pointer address, upper nibble next.
// RULE_16: Skip when accumulator pair equals the selected pair.
// RULE_17: Carry set, clear, invert, and skip when carry is one.
// RULE_18: Direct bit set and clear touch only the chosen bit of four.
// RULE_19: Bit set and clear also work in the three bit addressing modes.
// RULE_20: Bit test skips on one (true form) or zero (false form).
// RULE_21: Test-and-clear skips when bit is one and clears it in same op.
// RULE_22: A skip discards the next operation with none of its updates.
// RULE_23: Only carry operations, subtract with borrow and rotate alter carry.
//
// Purpose: shared types and constants of the nibble datapath.
// Assumes: one core clock, decoder presents already decoded operations.
// Notes: register file order X A H L D E B C, alternate bank above it.
package nibble_alu_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_SBB_ACC_ANY, OP_SBB_DST_ACC,
    OP_AND_IMM, OP_AND_MEM, OP_AND_ACC_ANY, OP_AND_DST_ACC,
    OP_OR_IMM, OP_OR_MEM, OP_OR_ACC_ANY, OP_OR_DST_ACC,
    OP_XOR_IMM, OP_XOR_MEM, OP_XOR_ACC_ANY, OP_XOR_DST_ACC,
    OP_ROT_CARRY, OP_NOT_ACC,
    OP_INC_REG, OP_INC_PAIR, OP_INC_MEM_PTR, OP_INC_MEM_DIR,
    OP_DEC_REG, OP_DEC_PAIR,
    OP_EQ_REG_IMM, OP_EQ_PTR_IMM, OP_EQ_ACC_PTR, OP_EQ_WIDE_PTR,
    OP_EQ_ACC_REG, OP_EQ_ACC_PAIR,
    OP_CARRY_SET, OP_CARRY_CLR, OP_CARRY_TEST, OP_CARRY_INV,
    OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST_T, OP_BIT_TEST_F, OP_BIT_TEST_CLR
  } op_t;

  typedef enum logic [1:0] {
    BM_DIRECT, BM_FIXED, BM_PTR_LOW, BM_HIGH_REL
  } bit_mode_t;

  typedef enum logic [1:0] {LF_AND, LF_OR, LF_XOR, LF_SUB} logic_fn_t;

  localparam logic [3:0] IDX_X = 4'h0;
  localparam logic [3:0] IDX_A = 4'h1;
  localparam logic [3:0] IDX_H = 4'h2;
  localparam logic [3:0] IDX_L = 4'h3;
  localparam logic [2:0] PAIR_ACC = 3'h0;
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [3:0] FIXED_PAGE = 4'hF;
  localparam logic [3:0] NIB_ONES = 4'hF;
  localparam logic [7:0] PAIR_ONES = 8'hFF;

  // Pair p holds its high nibble at even index, low nibble at odd index
  function automatic logic [3:0] pair_idx(input logic [2:0] p,
                                          input logic lo);
    pair_idx = {p, lo};
  endfunction

  function automatic logic [3:0] bit_mask(input logic [1:0] b);
    bit_mask = 4'h1 << b;
  endfunction

endpackage

//--- verilog/pair_logic_unit.sv
// Purpose: 8-bit AND, OR, XOR and subtract with borrow in.
// Assumes: nibble operations use the low four bits only.
// Notes: purely combinational.
`timescale 1ns/1ps
module pair_logic_unit
  import nibble_alu_pkg::*;
(
  input wire logic_fn_t fn_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic borrow_in,
  output logic [7:0] y_out,
  output logic borrow_out
);
  logic [8:0] diff;

  // Borrow is the ninth bit of the widened difference
  assign diff = {1'b0, a_in} - {1'b0, b_in} - {8'h00, borrow_in};

  always_comb begin
    borrow_out = 1'b0;
    case (fn_in)
      LF_AND: y_out = a_in & b_in;
      LF_OR: y_out = a_in | b_in;
      LF_XOR: y_out = a_in ^ b_in;
      LF_SUB: begin
        y_out = diff[7:0];
        borrow_out = diff[8];
      end
      default: y_out = a_in;
    endcase
  end
endmodule
